// file: tmw_regs.vh
// tmw_regs.vh - register map, field codes and fixed values of the
// 16-bit waveform timer; included by tmw_timer.v, definitions only
`ifndef TMW_REGS_VH
`define TMW_REGS_VH

// byte offsets on the register bus
`define TMW_A_CTRL_A  8'h00
`define TMW_A_CTRL_B  8'h04
`define TMW_A_COUNT   8'h08
`define TMW_A_CMP_A   8'h0c
`define TMW_A_CMP_B   8'h10
`define TMW_A_CMP_C   8'h14
`define TMW_A_CAPT    8'h18
`define TMW_A_FLAGS   8'h1c

// reset values
`define TMW_RST_CTRL_A 8'h00
`define TMW_RST_CTRL_B 5'h00
`define TMW_RST_16     16'h0000

// fixed TOP values
`define TMW_TOP_MAX   16'hffff
`define TMW_TOP_8     16'h00ff
`define TMW_TOP_9     16'h01ff
`define TMW_TOP_10    16'h03ff

// waveform modes
`define TMW_M_NORMAL  4'h0
`define TMW_M_PC8     4'h1
`define TMW_M_PC9     4'h2
`define TMW_M_PC10    4'h3
`define TMW_M_CTC_A   4'h4
`define TMW_M_FP8     4'h5
`define TMW_M_FP9     4'h6
`define TMW_M_FP10    4'h7
`define TMW_M_PFC_CAP 4'h8
`define TMW_M_PFC_A   4'h9
`define TMW_M_PC_CAP  4'ha
`define TMW_M_PC_A    4'hb
`define TMW_M_CTC_CAP 4'hc
`define TMW_M_RSVD    4'hd
`define TMW_M_FP_CAP  4'he
`define TMW_M_FP_A    4'hf

// tick source codes
`define TMW_CS_STOP   3'h0
`define TMW_CS_DIV1   3'h1
`define TMW_CS_DIV8   3'h2
`define TMW_CS_DIV64  3'h3
`define TMW_CS_DIV256 3'h4
`define TMW_CS_DIV1K  3'h5
`define TMW_CS_FALL   3'h6
`define TMW_CS_RISE   3'h7

// prescaler terminal masks
`define TMW_PRE_8     10'h007
`define TMW_PRE_64    10'h03f
`define TMW_PRE_256   10'h0ff
`define TMW_PRE_1K    10'h3ff

// output action codes
`define TMW_ACT_OFF   2'h0
`define TMW_ACT_TOG   2'h1
`define TMW_ACT_CLR   2'h2
`define TMW_ACT_SET   2'h3

// field positions
`define TMW_F_MODE_LO 1:0
`define TMW_F_MODE_HI 4:3
`define TMW_F_CS      2:0
`define TMW_F_OVF     0

`endif

// file: tmw_timer.v
// tmw_timer.v - 16-bit timer with three waveform channels and an
// AHB-Lite register slave.
// assumes one clock, synchronous inputs, a single bus master.
// Summary of operation
// - synchronous counter, tick is only a clock enable
// - buffered compare loads at mode update point
// - bottom events mirror top event timing
// - control A: actions A/B/C, low mode bits
// - supported nonzero action replaces pin port function, except in mode 13
// - action meaning depends on waveform mode class
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: clear/set on match, opposite at TOP
// - fast PWM toggle only channel A, modes 14/15
// - fast PWM compare equal TOP: TOP action only
// - dual slope: code sets direction-dependent level
// - dual slope toggle only channel A, modes 8-11
// - mode joins control A and B bits
// - modes 0, 4, 12: immediate update, overflow MAX
// - modes 1-3: fixed TOP, update TOP, flag BOTTOM
// - modes 5-7: fixed TOP, update and flag TOP
// - modes 8, 9: update and flag at BOTTOM
// - modes 10/11 and 14/15 variable TOP
// - tick source: stop, divide, external edges
// - bottom flag set with compare reload tick in modes 8, 9
`timescale 1ns/100ps
`include "tmw_regs.vh"

module tmw_timer #(
    parameter PRE_W = 10
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        ext_tick_pin,
    output wire        wave_out_a,
    output wire        wave_out_b,
    output wire        wave_out_c,
    output wire        wave_pin_own_a,
    output wire        wave_pin_own_b,
    output wire        wave_pin_own_c
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [7:0]       wave_control_a;
reg  [4:0]       wave_control_b;
reg  [15:0]      count_value;
reg  [15:0]      capture_value;
reg              count_up;
reg              overflow_flag;
reg  [PRE_W-1:0] prescale;
reg              ext_prev;
reg              d_act;
reg              d_wr;
reg  [7:0]       d_addr;
reg  [15:0]      cmp_buf [0:2];
reg  [15:0]      cmp_act [0:2];
reg  [2:0]       wave_lvl;
reg  [2:0]       compare_match_flag;
reg              tick;
reg  [15:0]      top;
reg  [31:0]      rd_mux;

wire [3:0] waveform_mode_select;
wire [2:0] tick_source_select;
wire       accept;
wire       wr_now;
wire [15:0] wdata;
wire [2:0] own_w;

// ----------------------------------------------------------------
// mode decode
// ----------------------------------------------------------------
assign waveform_mode_select = {wave_control_b[`TMW_F_MODE_HI],
                               wave_control_a[`TMW_F_MODE_LO]};
assign tick_source_select = wave_control_b[`TMW_F_CS];

wire m_rsvd = (waveform_mode_select == `TMW_M_RSVD);
wire m_fast = (waveform_mode_select == `TMW_M_FP8)
           || (waveform_mode_select == `TMW_M_FP9)
           || (waveform_mode_select == `TMW_M_FP10)
           || (waveform_mode_select == `TMW_M_FP_CAP)
           || (waveform_mode_select == `TMW_M_FP_A);
wire m_pfc  = (waveform_mode_select == `TMW_M_PFC_CAP)
           || (waveform_mode_select == `TMW_M_PFC_A);
wire m_pc_v = (waveform_mode_select == `TMW_M_PC_CAP)
           || (waveform_mode_select == `TMW_M_PC_A);
wire m_pc_f = (waveform_mode_select == `TMW_M_PC8)
           || (waveform_mode_select == `TMW_M_PC9)
           || (waveform_mode_select == `TMW_M_PC10);
wire m_dual = m_pfc || m_pc_v || m_pc_f;
wire m_npwm = !m_fast && !m_dual && !m_rsvd;
wire m_fix  = m_pc_f || (m_fast && !waveform_mode_select[3]);
wire fast_tog = (waveform_mode_select == `TMW_M_FP_CAP)
             || (waveform_mode_select == `TMW_M_FP_A);
wire dual_tog = m_pfc || m_pc_v;

// TOP source per mode
always @* begin
    case (waveform_mode_select)
        `TMW_M_PC8, `TMW_M_FP8:    top = `TMW_TOP_8;
        `TMW_M_PC9, `TMW_M_FP9:    top = `TMW_TOP_9;
        `TMW_M_PC10, `TMW_M_FP10:  top = `TMW_TOP_10;
        `TMW_M_CTC_A, `TMW_M_PFC_A,
        `TMW_M_PC_A, `TMW_M_FP_A:  top = cmp_act[0];
        `TMW_M_CTC_CAP, `TMW_M_PFC_CAP,
        `TMW_M_PC_CAP, `TMW_M_FP_CAP: top = capture_value;
        default:                   top = `TMW_TOP_MAX;
    endcase
end

wire at_top = (count_value == top);
wire at_bot = (count_value == `TMW_RST_16);
wire at_max = (count_value == `TMW_TOP_MAX);

// compare reload point: immediate, TOP or BOTTOM
wire upd_ev = tick && ((m_pfc && at_bot)
           || ((m_fast || m_pc_v || m_pc_f) && at_top));
// overflow point: MAX in non-PWM, TOP in fast PWM, BOTTOM in every dual slope mode
wire ovf_ev = tick && ((m_npwm && at_max)
           || (m_fast && at_top)
           || (m_dual && at_bot));

// ----------------------------------------------------------------
// tick source
// ----------------------------------------------------------------
always @* begin
    tick = 1'b0;
    if (ce && !m_rsvd) begin
        case (tick_source_select)
            `TMW_CS_DIV1:   tick = 1'b1;
            `TMW_CS_DIV8:   tick = (prescale[9:0] & `TMW_PRE_8)
                                   == `TMW_PRE_8;
            `TMW_CS_DIV64:  tick = (prescale[9:0] & `TMW_PRE_64)
                                   == `TMW_PRE_64;
            `TMW_CS_DIV256: tick = (prescale[9:0] & `TMW_PRE_256)
                                   == `TMW_PRE_256;
            `TMW_CS_DIV1K:  tick = (prescale[9:0] & `TMW_PRE_1K)
                                   == `TMW_PRE_1K;
            `TMW_CS_FALL:   tick = ext_prev && !ext_tick_pin;
            `TMW_CS_RISE:   tick = !ext_prev && ext_tick_pin;
            default:        tick = 1'b0;
        endcase
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        prescale <= {PRE_W{1'b0}};
        ext_prev <= 1'b0;
    end else if (ce) begin
        ext_prev <= ext_tick_pin;
        if (tick_source_select == `TMW_CS_STOP)
            prescale <= {PRE_W{1'b0}};
        else
            prescale <= prescale + 1'b1;
    end
end

// ----------------------------------------------------------------
// bus slave
// ----------------------------------------------------------------
assign hreadyout = ce;
assign hresp     = 1'b0;
assign accept    = ce && hready && hsel && htrans[1];
assign wr_now    = ce && d_act && d_wr;
assign wdata     = hwdata[15:0];

wire wr_ctrl_a = wr_now && (d_addr == `TMW_A_CTRL_A);
wire wr_ctrl_b = wr_now && (d_addr == `TMW_A_CTRL_B);
wire wr_count  = wr_now && (d_addr == `TMW_A_COUNT);
wire wr_capt   = wr_now && (d_addr == `TMW_A_CAPT);
wire wr_flags  = wr_now && (d_addr == `TMW_A_FLAGS);
wire [2:0] wr_cmp;
assign wr_cmp[0] = wr_now && (d_addr == `TMW_A_CMP_A);
assign wr_cmp[1] = wr_now && (d_addr == `TMW_A_CMP_B);
assign wr_cmp[2] = wr_now && (d_addr == `TMW_A_CMP_C);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        d_act  <= 1'b0;
        d_wr   <= 1'b0;
        d_addr <= 8'h00;
    end else if (ce && hready) begin
        d_act  <= hsel && htrans[1];
        d_wr   <= hwrite;
        d_addr <= haddr;
    end
end

// read data captured in the address phase, shown in the data phase
always @* begin
    rd_mux = 32'h0000_0000;
    if (haddr == `TMW_A_CTRL_A)
        rd_mux[7:0] = wave_control_a;
    else if (haddr == `TMW_A_CTRL_B)
        rd_mux[4:0] = wave_control_b;
    else if (haddr == `TMW_A_COUNT)
        rd_mux[15:0] = count_value;
    else if (haddr == `TMW_A_CMP_A)
        rd_mux[15:0] = cmp_buf[0];
    else if (haddr == `TMW_A_CMP_B)
        rd_mux[15:0] = cmp_buf[1];
    else if (haddr == `TMW_A_CMP_C)
        rd_mux[15:0] = cmp_buf[2];
    else if (haddr == `TMW_A_CAPT)
        rd_mux[15:0] = capture_value;
    else if (haddr == `TMW_A_FLAGS)
        rd_mux[3:0] = {compare_match_flag, overflow_flag};
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        hrdata <= 32'h0000_0000;
    else if (accept && !hwrite)
        hrdata <= rd_mux;
end

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wave_control_a <= `TMW_RST_CTRL_A;
        wave_control_b <= `TMW_RST_CTRL_B;
        capture_value  <= `TMW_RST_16;
    end else begin
        if (wr_ctrl_a)
            wave_control_a <= hwdata[7:0];
        if (wr_ctrl_b)
            wave_control_b <= hwdata[4:0];
        if (wr_capt)
            capture_value <= wdata;
    end
end

// ----------------------------------------------------------------
// counter
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        count_value <= `TMW_RST_16;
        count_up    <= 1'b1;
    end else if (ce) begin
        if (wr_count) begin
            count_value <= wdata;
        end else if (m_rsvd) begin
            count_value <= `TMW_RST_16;
            count_up    <= 1'b1;
        end else if (tick) begin
            if (!m_dual) begin
                if (at_top)
                    count_value <= `TMW_RST_16;
                else
                    count_value <= count_value + 1'b1;
            end else if (count_up) begin
                if (at_top) begin
                    count_up    <= 1'b0;
                    count_value <= count_value - 1'b1;
                end else begin
                    count_value <= count_value + 1'b1;
                end
            end else begin
                if (at_bot) begin
                    count_up    <= 1'b1;
                    count_value <= count_value + 1'b1;
                end else begin
                    count_value <= count_value - 1'b1;
                end
            end
        end
    end
end

// overflow flag: hardware set wins over a write-one clear
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        overflow_flag <= 1'b0;
    else if (ovf_ev)
        overflow_flag <= 1'b1;
    else if (wr_flags && hwdata[`TMW_F_OVF])
        overflow_flag <= 1'b0;
end

// ----------------------------------------------------------------
// compare channels
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
        wire [1:0] act = wave_control_a[7-2*i:6-2*i];
        wire tog_ok = (i == 0) && (m_fast ? fast_tog
                                          : dual_tog);
        wire match = tick && (count_value == cmp_act[i]);
        wire [15:0] wmask = m_fix ? (wdata & top) : wdata;

        // pin ownership follows a supported nonzero action field, never in mode 13
        assign own_w[i] = (act != `TMW_ACT_OFF)
                       && !m_rsvd
                       && !(act == `TMW_ACT_TOG
                            && !m_npwm && !tog_ok);

        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cmp_buf[i] <= `TMW_RST_16;
                cmp_act[i] <= `TMW_RST_16;
            end else if (ce) begin
                if (wr_cmp[i])
                    cmp_buf[i] <= wmask;
                if (wr_cmp[i] && m_npwm)
                    cmp_act[i] <= wmask;
                else if (upd_ev)
                    cmp_act[i] <= cmp_buf[i];
                else if (m_npwm)
                    cmp_act[i] <= cmp_buf[i];
            end
        end

        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
                compare_match_flag[i] <= 1'b0;
            else if (match)
                compare_match_flag[i] <= 1'b1;
            else if (wr_flags && hwdata[i+1])
                compare_match_flag[i] <= 1'b0;
        end

        // output level by mode class and action code
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                wave_lvl[i] <= 1'b0;
            end else if (tick) begin
                if (m_npwm) begin
                    if (match) begin
                        case (act)
                            `TMW_ACT_TOG: wave_lvl[i] <= !wave_lvl[i];
                            `TMW_ACT_CLR: wave_lvl[i] <= 1'b0;
                            `TMW_ACT_SET: wave_lvl[i] <= 1'b1;
                            default:      wave_lvl[i] <= wave_lvl[i];
                        endcase
                    end
                end else if (m_fast) begin
                    if (act[1]) begin
                        if (at_top)
                            wave_lvl[i] <= !act[0];
                        else if (match)
                            wave_lvl[i] <= act[0];
                    end else if (act[0] && tog_ok && match) begin
                        wave_lvl[i] <= !wave_lvl[i];
                    end
                end else if (m_dual) begin
                    if (act[1]) begin
                        if (match)
                            wave_lvl[i] <= act[0] ~^ count_up;
                    end else if (act[0] && tog_ok && match) begin
                        wave_lvl[i] <= !wave_lvl[i];
                    end
                end
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign wave_out_a     = wave_lvl[0];
assign wave_out_b     = wave_lvl[1];
assign wave_out_c     = wave_lvl[2];
assign wave_pin_own_a = own_w[0];
assign wave_pin_own_b = own_w[1];
assign wave_pin_own_c = own_w[2];

endmodule // tmw_timer

// file: tmw_timer_sva.sv
// tmw_timer_sva.sv - bus and pin checks on the waveform timer
// assumes one clock, hready fed from hreadyout, word transfers
`timescale 1ns/100ps
`include "tmw_regs.vh"

module tmw_timer_sva (
    input wire        hclk,
    input wire        hresetn,
    input wire        ce,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        wave_out_a,
    input wire        wave_out_b,
    input wire        wave_out_c,
    input wire        wave_pin_own_a,
    input wire        wave_pin_own_b,
    input wire        wave_pin_own_c
);
    // ----------------------------------------------------------
    // shadow of the control words, built from bus writes
    // ----------------------------------------------------------
    reg  [7:0] sh_a;
    reg  [4:0] sh_b;
    reg        wr_pend;
    reg  [7:0] wr_adr;
    wire [3:0] mode = {sh_b[4:3], sh_a[1:0]};
    wire [2:0] wv   = {wave_out_c, wave_out_b, wave_out_a};
    wire [2:0] own  = {wave_pin_own_c, wave_pin_own_b, wave_pin_own_a};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_a    <= 8'h00;
            sh_b    <= 5'h00;
            wr_pend <= 1'b0;
            wr_adr  <= 8'h00;
        end else if (ce) begin
            if (wr_pend && wr_adr == `TMW_A_CTRL_A)
                sh_a <= hwdata[7:0];
            if (wr_pend && wr_adr == `TMW_A_CTRL_B)
                sh_b <= hwdata[4:0];
            wr_pend <= hsel && htrans[1] && hwrite && hready;
            wr_adr  <= haddr;
        end
    end

    function automatic logic own_f(input logic [3:0] m,
                                   input logic [1:0] c, input logic is_a);
        if (m == `TMW_M_RSVD || c == `TMW_ACT_OFF)
            return 1'b0;
        if (c != `TMW_ACT_TOG || m == `TMW_M_NORMAL || m == `TMW_M_CTC_A
            || m == `TMW_M_CTC_CAP)
            return 1'b1;
        return is_a && m[3];
    endfunction

    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd(logic [7:0] a);
        hsel && htrans[1] && !hwrite && hready && haddr == a;
    endsequence
    sequence s_rd_hole;
        hsel && htrans[1] && !hwrite && hready && haddr >= 8'h20;
    endsequence
    sequence s_still;
        sh_b[2:0] == `TMW_CS_STOP && !wr_pend ##1 sh_b[2:0] == `TMW_CS_STOP;
    endsequence

    property p_ready; hreadyout == ce; endproperty
    property p_okay; !hresp; endproperty
    property p_own_a; wave_pin_own_a == own_f(mode, sh_a[7:6], 1'b1);
    endproperty
    property p_own_b; wave_pin_own_b == own_f(mode, sh_a[5:4], 1'b0);
    endproperty
    property p_own_c; wave_pin_own_c == own_f(mode, sh_a[3:2], 1'b0);
    endproperty
    property p_rsvd; mode == `TMW_M_RSVD |-> own == 3'h0; endproperty
    // read data is captured at the address edge, before any write there
    property p_rd_ctrl;
        s_rd(`TMW_A_CTRL_A) |=> hrdata == {24'h0, $past(sh_a)};
    endproperty
    property p_hole; s_rd_hole |=> hrdata == 32'h0; endproperty
    property p_freeze; !ce |=> $stable(wv) && $stable(hrdata); endproperty
    property p_stop; s_still |=> $stable(wv); endproperty

    a_ready: assert property (p_ready) else $error("ready not ce");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_own_a: assert property (p_own_a) else $error("own a");
    a_own_b: assert property (p_own_b) else $error("own b");
    a_own_c: assert property (p_own_c) else $error("own c");
    a_rsvd: assert property (p_rsvd) else $error("reserved owns");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl a");
    a_hole: assert property (p_hole) else $error("unmapped read data");
    a_freeze: assert property (p_freeze) else $error("moved at ce low");
    a_stop: assert property (p_stop) else $error("moved when stopped");
endmodule // tmw_timer_sva

bind tmw_timer tmw_timer_sva tmw_timer_sva_i (.hclk, .hresetn, .ce, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .wave_out_a, .wave_out_b, .wave_out_c, .wave_pin_own_a, .wave_pin_own_b,
    .wave_pin_own_c);

// file: tmw_timer_test.sv
// tmw_timer_test.sv - self-checking bench of the waveform timer
// assumes the timer with its checker bound, one 100 MHz clock
`timescale 1ns/100ps
`include "tmw_regs.vh"

module tmw_timer_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        ext_tick_pin = 1'b0;
    logic [31:0] rs = 32'h4aef8405;
    logic [31:0] rd;
    wire         hready;
    wire  [31:0] hrdata;
    wire  [2:0]  wv;
    wire  [2:0]  own;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;
    int          r;
    int          pin_div = 0;

    always #5 hclk = ~hclk;

    // pin toggles every three cycles, one rising edge in six
    always @(posedge hclk) begin
        pin_div <= (pin_div + 1) % 3;
        if (pin_div == 2)
            ext_tick_pin <= ~ext_tick_pin;
    end

    tmw_timer tmw_timer_i (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(),
        .hrdata(hrdata), .ext_tick_pin(ext_tick_pin),
        .wave_out_a(wv[0]), .wave_out_b(wv[1]), .wave_out_c(wv[2]),
        .wave_pin_own_a(own[0]), .wave_pin_own_b(own[1]),
        .wave_pin_own_c(own[2])
    );

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic own_exp(input logic [3:0] m,
                                     input logic [1:0] c, input logic is_a);
        if (m == 4'hd || c == 2'h0)
            return 1'b0;
        if (c != 2'h1 || m == 4'h0 || m == 4'h4 || m == 4'hc)
            return 1'b1;
        return is_a && m[3];
    endfunction

    // toggle interval at TOP 1 is two ticks
    function automatic int iv_exp(input int cs);
        case (cs)
            1: return 2;
            2: return 16;
            3: return 128;
            4: return 512;
            5: return 2048;
            default: return 12;
        endcase
    endfunction

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input string nm);
        $display("[FAIL] %s expected an edge seen none", nm);
        fail_count++;
        give_verdict();
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
            k++;
            if (k > 1000)
                hang("bus ready");
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask

    task automatic cfg(input logic [3:0] m, input logic [2:0] cs,
                       input logic [5:0] act);
        bus(1'b1, `TMW_A_CTRL_A, {24'h0, act, m[1:0]});
        bus(1'b1, `TMW_A_CTRL_B, {27'h0, m[3:2], cs});
        @(posedge hclk);
    endtask

    // cycles one channel holds lvl, measured over a whole pulse
    task automatic span(input int ch, input logic lvl, output int cnt);
        for (int s = 0; s < 3; s++) begin
            cnt = 0;
            while ((wv[ch] === lvl) == (s != 1)) begin
                @(posedge hclk);
                cnt++;
                if (cnt > 8000)
                    hang("waveform edge");
            end
        end
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 32; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        for (int i = 0; i < 8; i++) begin
            rs = xs(rs);
            bus(1'b1, `TMW_A_CTRL_A, rs);
            bus(1'b1, `TMW_A_CTRL_B, rs & 32'h18);
            bus(1'b1, 8'h24, ~rs);
            bus(1'b0, `TMW_A_CTRL_A, 32'h0);
            chk("control a", {24'h0, rs[7:0]}, rd);
            bus(1'b0, `TMW_A_CTRL_B, 32'h0);
            chk("control b", {27'h0, rs[4:3], 3'h0}, rd);
            bus(1'b0, 8'h24, 32'h0);
            chk("unmapped", 32'h0, rd);
        end
        for (int m = 0; m < 16; m++) begin
            for (int c = 0; c < 4; c++) begin
                cfg(4'(m), 3'h0, {3{2'(c)}});
                chk("pin owner", {29'h0, own_exp(4'(m), 2'(c), 1'b0),
                    own_exp(4'(m), 2'(c), 1'b0),
                    own_exp(4'(m), 2'(c), 1'b1)}, {29'h0, own});
            end
        end
        // clear on match A: toggle, set, clear, every tick source but stop
        cfg(`TMW_M_CTC_A, 3'h0, 6'b011011 ^ 6'b000101);
        bus(1'b1, `TMW_A_CMP_A, 32'h1);
        bus(1'b1, `TMW_A_CMP_B, 32'h0);
        bus(1'b1, `TMW_A_CMP_C, 32'h1);
        bus(1'b1, `TMW_A_COUNT, 32'h0);
        bus(1'b1, `TMW_A_FLAGS, 32'hf);
        for (int cs = 1; cs < 8; cs++) begin
            bus(1'b1, `TMW_A_CTRL_B, {27'h0, 2'b01, 3'(cs)});
            span(0, 1'b1, n);
            chk("toggle interval", 32'(iv_exp(cs)), 32'(n));
        end
        chk("clear and set", 32'h1, {30'h0, wv[2:1]});
        bus(1'b0, `TMW_A_FLAGS, 32'h0);
        chk("flags below max", 32'h2, {30'h0, rd[1:0]});
        // fast pwm, 8-bit top, random duty, compare C at top
        rs = xs(rs);
        r = int'(rs[7:0]) % 254 + 1;
        cfg(`TMW_M_FP8, 3'h0, 6'b101110);
        bus(1'b1, `TMW_A_CMP_A, 32'(r));
        bus(1'b1, `TMW_A_CMP_B, 32'(r));
        bus(1'b1, `TMW_A_CMP_C, 32'hff);
        bus(1'b1, `TMW_A_FLAGS, 32'hf);
        bus(1'b1, `TMW_A_CTRL_B, 32'h09);
        span(0, 1'b1, n);
        ce <= 1'b0;
        repeat (6) @(posedge hclk);
        ce <= 1'b1;
        span(0, 1'b1, n);
        chk("fast high width", 32'(r + 1), 32'(n));
        span(1, 1'b0, n);
        chk("fast low width", 32'(r + 1), 32'(n));
        chk("compare at top", 32'h1, {31'h0, wv[2]});
        bus(1'b0, `TMW_A_FLAGS, 32'h0);
        chk("overflow at top", 32'h1, {31'h0, rd[0]});
        // phase correct, 8-bit top, random duty
        rs = xs(rs);
        r = int'(rs[7:0]) % 254 + 1;
        cfg(`TMW_M_PC8, 3'h0, 6'b101100);
        bus(1'b1, `TMW_A_CMP_A, 32'(r));
        bus(1'b1, `TMW_A_CMP_B, 32'(r));
        bus(1'b1, `TMW_A_FLAGS, 32'hf);
        bus(1'b1, `TMW_A_CTRL_B, 32'h01);
        span(0, 1'b0, n);
        span(0, 1'b0, n);
        chk("dual low width", 32'(2 * (255 - r)), 32'(n));
        span(1, 1'b1, n);
        chk("dual high width", 32'(2 * (255 - r)), 32'(n));
        bus(1'b0, `TMW_A_FLAGS, 32'h0);
        chk("overflow at bottom", 32'h1, {31'h0, rd[0]});
        give_verdict();
    end
endmodule // tmw_timer_test
